// [bench/bcd_arith_divide_decoder_tb.sv]
/*
 self-checking bench for the decimal, decrement and divide decoder.
 assumes the checker is bound in by its own file.
*/
`timescale 1ns/1ps
module bcd_arith_divide_decoder_tb;
	logic       clk = 1'b0, reset = 1'b1, fetch_valid = 1'b0, div_early = 1'b0;
	logic [7:0] fetch_byte0 = 8'h00, fetch_byte1 = 8'h00;
	logic       decode_ready, op_size, busy, done, illegal;
	logic [3:0] operand_sel;
	logic [2:0] instr_len;
	logic [4:0] cycle_budget;
	bcd_div_pkg::op_kind_e op_kind;
	int         n_errors = 0, samples_checked = 0;
	logic [15:0] corner [25] = '{16'h7cec, 16'h7dec, 16'h7ce4, 16'h7cef, 16'h7ce7, 16'h7ce1, 16'h7de1,
		16'h7ce0, 16'h7de0, 16'h7ce3, 16'h7de3, 16'h76d0, 16'h77d5, 16'h77c6, 16'h76cf, 16'h779b,
		16'hab00, 16'hac00, 16'had00, 16'hae00, 16'haf00, 16'hf200, 16'hfa00, 16'h7de4, 16'h7def};
	// free-running core clock, 10 ns
	always #5 clk = ~clk;
	bcd_arith_divide_decoder uut (.clk(clk), .reset(reset), .fetch_valid(fetch_valid),
		.fetch_byte0(fetch_byte0), .fetch_byte1(fetch_byte1), .div_early(div_early),
		.decode_ready(decode_ready), .op_kind(op_kind), .op_size(op_size), .operand_sel(operand_sel),
		.instr_len(instr_len), .cycle_budget(cycle_budget), .busy(busy), .done(done), .illegal(illegal));
	// one compare, counted; four-state equality so x never matches
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// reference decode; a kind of zero means the bytes are outside the group
	function automatic void ref_dec(input logic [7:0] b0, input logic [7:0] b1, output logic [2:0] k,
		output logic [2:0] len, output logic [4:0] cyc, output logic [3:0] sel, output logic sz);
		logic mem;
		sz = b0[0];
		mem = b0[7:1] == 7'h3b && b1[3:0] > 4'h5;
		k = bcd_div_pkg::OP_NONE;
		sel = 4'h0;
		len = 3'h1;
		cyc = 5'h01;
		if (b0[7:1] == 7'h3e) begin
			len = (b1 == 8'he4 || b1 == 8'he7) ? 3'h2 : 3'h3 + 3'(sz);
			case (b1)
				8'hec, 8'he4: k = bcd_div_pkg::OP_BCD_ADD;
				8'hef, 8'he7: k = bcd_div_pkg::OP_BCD_SUB;
				8'he1: k = bcd_div_pkg::OP_SQUOT;
				8'he0: k = bcd_div_pkg::OP_UQUOT;
				8'he3: k = bcd_div_pkg::OP_SQUOT_ALT;
				default: k = bcd_div_pkg::OP_NONE;
			endcase
			if (sz && b1 != 8'hec && b1[7:2] != 6'h38)
				k = bcd_div_pkg::OP_NONE;
		end
		if (b0[7:1] == 7'h3b) begin
			k = b1[7:4] == 4'hd ? bcd_div_pkg::OP_SQUOT : b1[7:4] == 4'hc ? bcd_div_pkg::OP_UQUOT :
				b1[7:4] == 4'h9 ? bcd_div_pkg::OP_SQUOT_ALT : bcd_div_pkg::OP_NONE;
			sel = b1[3:0];
			len = 3'h2 + 3'(b1[3]) + 3'(b1[3] & b1[2]);
		end
		if (b0[7:3] == 5'h15 && b0[2:0] > 3'h2) begin
			k = bcd_div_pkg::OP_MINUS_ONE;
			sel = {1'b0, b0[2:0]};
			len = b0[2:0] == 3'h7 ? 3'h3 : b0[2:0] > 3'h4 ? 3'h2 : 3'h1;
			cyc = b0[2:0] > 3'h4 ? 5'h03 : 5'h01;
			sz = 1'b0;
		end
		if (b0[7:4] == 4'hf && b0[2:0] == 3'h2) begin
			k = bcd_div_pkg::OP_MINUS_ONE;
			sel = {3'h0, b0[3]};
			sz = 1'b1;
		end
		case (k)
			bcd_div_pkg::OP_BCD_ADD: cyc = 5'h05;
			bcd_div_pkg::OP_BCD_SUB: cyc = 5'h04;
			bcd_div_pkg::OP_UQUOT: cyc = 5'h12 + (sz ? 5'h07 : 5'h00) + (mem ? 5'h02 : 5'h00);
			bcd_div_pkg::OP_SQUOT, bcd_div_pkg::OP_SQUOT_ALT: cyc = 5'h16 + (sz ? 5'h06 : 5'h00) + (mem ? 5'h02 : 5'h00);
			default: cyc = cyc;
		endcase
	endfunction
	// offer one instruction at a falling edge and follow it to its end;
	// mode 1 pulses the early finish, mode 2 keeps offering while busy
	task automatic run(input logic [15:0] ins, input int mode);
		logic [2:0] k, len;
		logic [4:0] cyc;
		logic [3:0] sel;
		logic       sz;
		int         n;
		ref_dec(ins[15:8], ins[7:0], k, len, cyc, sel, sz);
		{fetch_byte0, fetch_byte1} = ins;
		fetch_valid = 1'b1;
		check("ready", decode_ready, 8'h01);
		@(negedge clk);
		check("illegal", illegal, k == 3'h0);
		// an unknown offer is left standing; the next call replaces it in this same step
		if (k != 3'h0) begin
			fetch_valid = mode == 2;
			fetch_byte0 = 8'hab;
		end
		n = 0;
		while (busy === 1'b1 && n < 40) begin
			div_early = mode == 1 && n == 1;
			@(negedge clk);
			n++;
		end
		div_early = 1'b0;
		check("done", done, k != 3'h0);
		if (k != 3'h0) begin
			if (mode == 1 && k > 3'h3)
				check("early finish", n, 8'h02);
			else
				check("cycles", n, cyc);
			check("kind", op_kind, k);
			check("length", instr_len, len);
			check("budget", cycle_budget, cyc);
			check("operand", operand_sel, sel);
			check("size", op_size, sz);
		end
	endtask
	// the single place where the run ends
	task automatic stop_test();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// cuts a hang short; the whole run needs well under 20000 cycles
	initial begin
		#200000;
		n_errors++;
		stop_test();
	end
	// reset, every documented form back to back, then seeded random traffic
	initial begin
		logic [7:0] b0;
		logic [7:0] tbl [12] = '{8'h7c, 8'h7d, 8'h76, 8'h77, 8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'hf2, 8'hfa, 8'h00};
		logic [7:0] op2 [7] = '{8'hec, 8'he4, 8'hef, 8'he7, 8'he1, 8'he0, 8'he3};
		logic [3:0] hi [3] = '{4'hd, 4'hc, 4'h9};
		void'($urandom(25490));
		repeat (12) @(negedge clk);
		reset = 1'b0;
		check("busy after reset", busy, 8'h00);
		foreach (corner[i])
			run(corner[i], 0);
		run(16'h77c3, 1);
		run(16'h7ce4, 1);
		run(16'h7ce7, 2);
		$display("corner cases finished");
		repeat (200) begin
			b0 = tbl[$urandom % 12];
			if (b0[7:1] == 7'h3b)
				run({b0, hi[$urandom % 3], 4'($urandom)}, $urandom % 3);
			else
				run({b0, op2[$urandom % 7]} & ~{15'h0000, b0 == 8'h7d}, $urandom % 3);
		end
		run(16'h7ce4, 0);
		$display("random traffic finished");
		stop_test();
	end
endmodule

// [bench/bcd_div_checker_sva.sv]
/*
 concurrent checks on the decimal, decrement and divide decoder.
 assumes it is bound to the decoder and sees only its ports.
*/
`timescale 1ns/1ps
module bcd_div_checker (
	input wire logic            clk,          // core clock
	input wire logic            reset,        // sync, high
	input wire logic            fetch_valid,  // offer
	input wire logic [7:0]      fetch_byte0,  // byte 0
	input wire logic [7:0]      fetch_byte1,  // byte 1
	input wire logic            decode_ready, // idle
	input bcd_div_pkg::op_kind_e op_kind,     // kind
	input wire logic [3:0]      operand_sel,  // field
	input wire logic [2:0]      instr_len,    // bytes
	input wire logic [4:0]      cycle_budget, // cycles
	input wire logic            busy,         // running
	input wire logic            done          // end pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic take;
	// an offer counts only on an edge where the decoder is idle
	assign take = fetch_valid && decode_ready;
	// fields settle one cycle after the offer is taken; run lengths follow
	add_imm_byte_a: assert property (take && fetch_byte0 == 8'h7c && fetch_byte1 == 8'hec
		|=> instr_len == 3'h3 && cycle_budget == 5'h05) else $error("byte add imm decode");
	add_imm_word_a: assert property (take && fetch_byte0 == 8'h7d && fetch_byte1 == 8'hec
		|=> instr_len == 3'h4 && cycle_budget == 5'h05) else $error("word add imm decode");
	add_reg_run_a: assert property (take && fetch_byte0 == 8'h7c && fetch_byte1 == 8'he4
		|=> (instr_len == 3'h2 && busy) ##1 busy[*4] ##1 done) else $error("add reg run");
	sub_reg_run_a: assert property (take && fetch_byte0 == 8'h7c && fetch_byte1 == 8'he7
		|=> (instr_len == 3'h2 && busy) ##1 busy[*3] ##1 done) else $error("sub reg run");
	minus_short_a: assert property (take && fetch_byte0[7:3] == 5'h15 && fetch_byte0[2:0] > 3'h2
		|=> operand_sel == {1'b0, $past(fetch_byte0[2:0])}
		&& cycle_budget == ($past(fetch_byte0[2:0]) < 3'h5 ? 5'h01 : 5'h03)) else $error("short decrement decode");
	minus_addr_a: assert property (take && fetch_byte0[7:4] == 4'hf && fetch_byte0[2:0] == 3'h2
		|=> (operand_sel == {3'h0, $past(fetch_byte0[3])} && busy) ##1 done)
		else $error("address register decrement");
	squot_word_a: assert property (take && fetch_byte0 == 8'h7d && fetch_byte1 == 8'he1
		|=> instr_len == 3'h4 && cycle_budget == 5'h1c) else $error("word signed imm");
	squot_mem_a: assert property (take && fetch_byte0 == 8'h76 && fetch_byte1[7:4] == 4'hd && fetch_byte1[3:0] > 4'h5
		|=> cycle_budget == 5'h18) else $error("signed mem source budget");
	cover property (done && op_kind == bcd_div_pkg::OP_SQUOT);
	cover property (done && op_kind == bcd_div_pkg::OP_MINUS_ONE);
	cover property (done ##1 busy);
endmodule
bind bcd_arith_divide_decoder bcd_div_checker chk_i (.clk(clk), .reset(reset), .fetch_valid(fetch_valid),
	.fetch_byte0(fetch_byte0), .fetch_byte1(fetch_byte1), .decode_ready(decode_ready), .op_kind(op_kind),
	.operand_sel(operand_sel), .instr_len(instr_len), .cycle_budget(cycle_budget), .busy(busy), .done(done));

// [core/bcd_arith_divide_decoder.sv]
/*
 decode and timing of the decimal add, decimal subtract with borrow,
 decrement and divide group. assumes the fetch path offers the first two
 instruction bytes on the core clock, holds them until accepted, and that
 the divider can report an early finish.
 a reset in mid-run drops the instruction in flight without an end pulse.
*/
`timescale 1ns/1ps
`include "bcd_div_consts.svh"

// Overview of operation
// - byte bcd add immediate: 3 bytes, 5 cycles
// - word bcd add immediate: 4 bytes, 5 cycles
// - bcd add high into low: 2/5
// - short decrement target field and timing
// - address register decrement: one byte, one cycle
// - signed divide immediate 3/22, word +1/+6
// - unsigned divide immediate 3/18, word +1/+7
// - alternate signed divide immediate, base 3/22
// - signed divide source: 22 reg, 24 mem
// - unsigned divide source: 18 reg, 20 mem
// - divide cycle counts are upper bounds
// - bcd subtract immediate: 3 bytes, 4 cycles
// - bcd subtract high from low: 2/4
module bcd_arith_divide_decoder (
	input  wire logic                 clk,          // core clock
	input  wire logic                 reset,        // synchronous, active high
	input  wire logic                 fetch_valid,  // first two bytes present
	input  wire logic [7:0]           fetch_byte0,  // first opcode byte
	input  wire logic [7:0]           fetch_byte1,  // second opcode byte
	input  wire logic                 div_early,    // divider finished before budget
	output logic                      decode_ready, // may accept next instruction
	output bcd_div_pkg::op_kind_e     op_kind,      // kind of accepted instruction
	output logic                      op_size,      // 0 byte, 1 word
	output logic [3:0]                operand_sel,  // target or source field
	output logic [2:0]                instr_len,    // bytes consumed
	output logic [4:0]                cycle_budget, // listed cycles
	output logic                      busy,         // executing
	output logic                      done,         // one-cycle end pulse
	output logic                      illegal       // one-cycle pulse, not in group
);

	logic                  hit_next;
	bcd_div_pkg::op_kind_e kind_next;
	logic                  size_next;
	logic [3:0]            sel_next;
	logic [2:0]            len_next;
	logic [4:0]            cyc_next;
	logic                  is_div;
	logic [3:0]            src;

	bcd_div_pkg::seq_state_e state_reg;
	bcd_div_pkg::op_kind_e   kind_reg;
	logic                    size_reg;
	logic [3:0]              sel_reg;
	logic [2:0]              len_reg;
	logic [4:0]              cyc_reg;
	logic [4:0]              count_reg;
	logic                    ready_reg;
	logic                    done_reg;
	logic                    illegal_reg;
	logic                    busy_reg;
	logic                    div_reg;
	logic                    accept;
	logic                    start;
	logic                    finish;
	logic                    end_run;

	// an offer is only looked at while idle; while running the fetch path is simply ignored
	assign src    = fetch_byte1[3:0];
	assign accept = fetch_valid && (state_reg == bcd_div_pkg::ST_IDLE);
	assign start  = accept && hit_next;

	// divide source length by operand mode; the budget and the word size penalty are set in the decode below
	function automatic logic [2:0] src_len(input logic [3:0] f);
		if (f >= `SRC_FIRST_DSP16) begin
			src_len = `LEN_4;
		end else if (f >= `SRC_FIRST_DSP8) begin
			src_len = `LEN_3;
		end else begin
			src_len = `LEN_2;
		end
	endfunction

	// pure decode of the offered bytes; nothing is latched unless accepted
	always_comb begin
		// defaults are the plain two-byte register add; each form overrides what differs
		hit_next  = 1'b1;
		kind_next = bcd_div_pkg::OP_NONE;
		size_next = fetch_byte0[0];
		sel_next  = 4'h0;
		len_next  = `LEN_2;
		cyc_next  = `CYC_BCD_ADD;
		is_div    = 1'b0;
		// target codes below the first register one belong to other instructions
		if (fetch_byte0[7:3] == `MINUS1_B_HI && fetch_byte0[2:0] >= `TGT_REG0_HIGH) begin
			kind_next = bcd_div_pkg::OP_MINUS_ONE;
			size_next = 1'b0;
			sel_next  = {1'b0, fetch_byte0[2:0]};
			case (fetch_byte0[2:0])
				`TGT_REG0_HIGH, `TGT_REG0_LOW: begin
					len_next = `LEN_1;
					cyc_next = `CYC_MINUS1_REG;
				end
				`TGT_ABSOLUTE: begin
					len_next = `LEN_3;
					cyc_next = `CYC_MINUS1_MEM;
				end
				default: begin
					len_next = `LEN_2;
					cyc_next = `CYC_MINUS1_MEM;
				end
			endcase
		end else if (fetch_byte0[7:4] == `MINUS1_W_HI && fetch_byte0[2:0] == `MINUS1_W_LO) begin
			kind_next = bcd_div_pkg::OP_MINUS_ONE;
			size_next = 1'b1;
			sel_next  = {3'h0, fetch_byte0[3]};
			len_next  = `LEN_1;
			cyc_next  = `CYC_MINUS1_REG;
		end else if (fetch_byte0 == `PFX_IMM_B && fetch_byte1 == `OP2_BCD_ADD_IMM) begin
			kind_next = bcd_div_pkg::OP_BCD_ADD;
			len_next  = `LEN_3;
		end else if (fetch_byte0 == `PFX_IMM_W && fetch_byte1 == `OP2_BCD_ADD_IMM) begin
			kind_next = bcd_div_pkg::OP_BCD_ADD;
			len_next  = `LEN_4;
		end else if (fetch_byte0 == `PFX_IMM_B && fetch_byte1 == `OP2_BCD_ADD_REG) begin
			kind_next = bcd_div_pkg::OP_BCD_ADD;
		end else if (fetch_byte0 == `PFX_IMM_B && fetch_byte1 == `OP2_BCD_SUB_IMM) begin
			kind_next = bcd_div_pkg::OP_BCD_SUB;
			len_next  = `LEN_3;
			cyc_next  = `CYC_BCD_SUB;
		end else if (fetch_byte0 == `PFX_IMM_B && fetch_byte1 == `OP2_BCD_SUB_REG) begin
			kind_next = bcd_div_pkg::OP_BCD_SUB;
			cyc_next  = `CYC_BCD_SUB;
		end else if ({fetch_byte0[7:1], 1'b0} == `PFX_IMM_B && (fetch_byte1 == `OP2_SQUOT_IMM
			|| fetch_byte1 == `OP2_UQUOT_IMM || fetch_byte1 == `OP2_SALT_IMM)) begin
			is_div   = 1'b1;
			len_next = fetch_byte0[0] ? `LEN_4 : `LEN_3;
			if (fetch_byte1 == `OP2_UQUOT_IMM) begin
				kind_next = bcd_div_pkg::OP_UQUOT;
				cyc_next  = fetch_byte0[0] ? `CYC_UQUOT_REG + `CYC_UQUOT_WADD : `CYC_UQUOT_REG;
			end else begin
				kind_next = (fetch_byte1 == `OP2_SALT_IMM) ? bcd_div_pkg::OP_SQUOT_ALT
				                                           : bcd_div_pkg::OP_SQUOT;
				cyc_next  = fetch_byte0[0] ? `CYC_SQUOT_REG + `CYC_SQUOT_WADD : `CYC_SQUOT_REG;
			end
		end else if (fetch_byte0[7:1] == `PFX_DIV_SRC_HI && (fetch_byte1[7:4] == `OP2_SQUOT_SRC_HI
			|| fetch_byte1[7:4] == `OP2_UQUOT_SRC_HI || fetch_byte1[7:4] == `OP2_SALT_SRC_HI)) begin
			is_div   = 1'b1;
			sel_next = src;
			len_next = src_len(src);
			if (fetch_byte1[7:4] == `OP2_UQUOT_SRC_HI) begin
				kind_next = bcd_div_pkg::OP_UQUOT;
				cyc_next  = ((src >= `SRC_FIRST_IND) ? `CYC_UQUOT_MEM : `CYC_UQUOT_REG)
				            + (fetch_byte0[0] ? `CYC_UQUOT_WADD : 5'h00);
			end else begin
				kind_next = (fetch_byte1[7:4] == `OP2_SALT_SRC_HI) ? bcd_div_pkg::OP_SQUOT_ALT
				                                                   : bcd_div_pkg::OP_SQUOT;
				cyc_next  = ((src >= `SRC_FIRST_IND) ? `CYC_SQUOT_MEM : `CYC_SQUOT_REG)
				            + (fetch_byte0[0] ? `CYC_SQUOT_WADD : 5'h00);
			end
		end else begin
			// word register add and word immediate subtract fall here as well
			hit_next = 1'b0;
		end
		// of the decimal forms only the immediate add has a word variant
		if (!is_div && kind_next != bcd_div_pkg::OP_MINUS_ONE) begin
			size_next = fetch_byte0[0] && (len_next == `LEN_4);
		end
	end

	// divides may stop on the divider's word before the budget runs out; other kinds ignore it
	assign finish = (count_reg == 5'h01) || (div_early && div_reg);

	// a run ends on the last counted cycle or on the divider's early word
	assign end_run = (state_reg == bcd_div_pkg::ST_RUN) && finish;

	// divide flag held with the kind so the early-finish gate is a single flop
	always_ff @(posedge clk) begin
		if (reset) begin
			div_reg <= 1'b0;
		end else if (start) begin
			div_reg <= is_div;
		end
	end

	// sequencer state: idle until a recognised instruction is taken, run until it ends
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= bcd_div_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				bcd_div_pkg::ST_IDLE: begin
					if (start) begin
						state_reg <= bcd_div_pkg::ST_RUN;
					end
				end
				bcd_div_pkg::ST_RUN: begin
					if (finish) begin
						state_reg <= bcd_div_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= bcd_div_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// budget counter: loaded on acceptance, one step per clock, so a budget of n gives n busy cycles
	always_ff @(posedge clk) begin
		if (reset) begin
			count_reg <= 5'h00;
		end else if (start) begin
			count_reg <= cyc_next;
		end else if (end_run) begin
			count_reg <= 5'h00;
		end else if (state_reg == bcd_div_pkg::ST_RUN) begin
			count_reg <= count_reg - 5'h01;
		end
	end

	// ready to take an offer whenever no instruction is running
	always_ff @(posedge clk) begin
		if (reset) begin
			ready_reg <= 1'b1;
		end else if (start) begin
			ready_reg <= 1'b0;
		end else if (end_run) begin
			ready_reg <= 1'b1;
		end
	end

	// busy has a flop of its own rather than an inverter so the port leaves a register
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_reg <= 1'b0;
		end else if (start) begin
			busy_reg <= 1'b1;
		end else if (end_run) begin
			busy_reg <= 1'b0;
		end
	end

	// end pulse: one cycle, so the core sees each completion exactly once
	always_ff @(posedge clk) begin
		if (reset) begin
			done_reg <= 1'b0;
		end else begin
			done_reg <= end_run;
		end
	end

	// instruction identity held for the whole run so the core reads it stably
	always_ff @(posedge clk) begin
		if (reset) begin
			kind_reg <= bcd_div_pkg::OP_NONE;
			size_reg <= 1'b0;
		end else if (start) begin
			kind_reg <= kind_next;
			size_reg <= size_next;
		end
	end

	// operand field: target of a decrement or divisor mode of a divide
	always_ff @(posedge clk) begin
		if (reset) begin
			sel_reg <= 4'h0;
		end else if (start) begin
			sel_reg <= sel_next;
		end
	end

	// the fetch path skips len bytes; the budget is the listed count, an upper bound for divides
	always_ff @(posedge clk) begin
		if (reset) begin
			len_reg <= 3'h0;
			cyc_reg <= 5'h00;
		end else if (start) begin
			len_reg <= len_next;
			cyc_reg <= cyc_next;
		end
	end

	// unknown byte pairs are flagged and dropped; the fetch path must move on
	always_ff @(posedge clk) begin
		if (reset) begin
			illegal_reg <= 1'b0;
		end else begin
			illegal_reg <= accept && !hit_next;
		end
	end

	assign decode_ready = ready_reg;
	assign op_kind      = kind_reg;
	assign op_size      = size_reg;
	assign operand_sel  = sel_reg;
	assign instr_len    = len_reg;
	assign cycle_budget = cyc_reg;
	assign busy         = busy_reg;
	assign done         = done_reg;
	assign illegal      = illegal_reg;

endmodule

// [core/bcd_div_consts.svh]
/*
 opcode patterns, field positions and timing figures for the decimal
 arithmetic, decrement and divide decoder. assumes nothing beyond being
 included by its bare name.
*/
`ifndef BCD_DIV_CONSTS_SVH
`define BCD_DIV_CONSTS_SVH

// first opcode byte of the two-byte forms; low bit is the size bit
`define PFX_IMM_B        8'h7c
`define PFX_IMM_W        8'h7d
`define PFX_DIV_SRC_HI   7'h3b
// second opcode byte
`define OP2_BCD_ADD_IMM  8'hec
`define OP2_BCD_ADD_REG  8'he4
`define OP2_BCD_SUB_IMM  8'hef
`define OP2_BCD_SUB_REG  8'he7
`define OP2_SQUOT_IMM    8'he1
`define OP2_UQUOT_IMM    8'he0
`define OP2_SALT_IMM     8'he3
`define OP2_SQUOT_SRC_HI 4'hd
`define OP2_UQUOT_SRC_HI 4'hc
`define OP2_SALT_SRC_HI  4'h9
// single-byte decrement forms
`define MINUS1_B_HI      5'h15
`define MINUS1_W_HI      4'hf
`define MINUS1_W_LO      3'h2
// short decrement target codes
`define TGT_REG0_HIGH    3'h3
`define TGT_REG0_LOW     3'h4
`define TGT_DSP_STATIC   3'h5
`define TGT_DSP_FRAME    3'h6
`define TGT_ABSOLUTE     3'h7
// divide source field boundaries
`define SRC_FIRST_IND    4'h6
`define SRC_FIRST_DSP8   4'h8
`define SRC_FIRST_DSP16  4'hc
// byte counts
`define LEN_1            3'h1
`define LEN_2            3'h2
`define LEN_3            3'h3
`define LEN_4            3'h4
// cycle counts
`define CYC_BCD_ADD      5'h05
`define CYC_BCD_SUB      5'h04
`define CYC_MINUS1_REG   5'h01
`define CYC_MINUS1_MEM   5'h03
`define CYC_SQUOT_REG    5'h16
`define CYC_SQUOT_MEM    5'h18
`define CYC_UQUOT_REG    5'h12
`define CYC_UQUOT_MEM    5'h14
`define CYC_SQUOT_WADD   5'h06
`define CYC_UQUOT_WADD   5'h07

`endif

// [core/bcd_div_pkg.sv]
/*
 types shared by the decoder and its bench. assumes the consts header
 carries every numeric figure.
*/
package bcd_div_pkg;

	// instruction kinds recognised by the decoder
	typedef enum logic [2:0] {
		OP_NONE,
		OP_BCD_ADD,
		OP_BCD_SUB,
		OP_MINUS_ONE,
		OP_SQUOT,
		OP_UQUOT,
		OP_SQUOT_ALT
	} op_kind_e;

	// sequencer states
	typedef enum logic {
		ST_IDLE,
		ST_RUN
	} seq_state_e;

endpackage
